// >>> tb/spi_host.sv
// Serial host model that frames commands for the protection block.
`timescale 1ns/1ns
module spi_host (
  // Clock
  input  wire logic clk_i,
  // Serial pins
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  input  wire logic so_i
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Frame task
  // ---------------------------------------------------------------------------
  // Mode 0 with every phase five cycles long, which covers the synchroniser delay.
  // The clock stands low between frames.
  task automatic frame(input logic [31:0] data, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk_i) cs_n_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    for (int i = nbits - 1; i >= 0; i--) begin
      si_o <= data[i];
      repeat (5) @(posedge clk_i);
      rx = {rx[6:0], so_i};
      sck_o <= 1'b1;
      repeat (5) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (5) @(posedge clk_i);
    cs_n_o <= 1'b1;
    // Released data line is flipped so a stale level is never mistaken for data.
    si_o <= ~si_o;
    repeat (5) @(posedge clk_i);
  endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking testbench of the status and write-protection block.
`timescale 1ns/1ns
`include "eeprom_guard_regs.svh"
`define CHECK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        sck, cs_n, si, so, so_oe_n, wr_go, refused;
  logic        wp_n = 1'b1;
  logic [7:0]  status, rx;
  logic [12:0] wr_addr;
  logic        so_line;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          n_ref = 0;
  int          n_go = 0;
  int          cycles = 0;

  always #5 clk_i = ~clk_i;

  eeprom_guard #(.WRITE_CYC(2000)) u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .wp_n_i(wp_n), .so_o(so), .so_oe_n_o(so_oe_n), .status_o(status),
    .array_wr_go_o(wr_go), .array_wr_addr_o(wr_addr), .write_refused_o(refused));

  // A released output line shows the inverse of its last value, so a read that
  // never enables the driver cannot pass.
  assign so_line = so_oe_n ? ~so : so;

  spi_host u_host (.clk_i(clk_i), .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so_line));

  // ---------------------------------------------------------------------------
  // Pulse counters and hang guard
  // ---------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (refused === 1'b1) n_ref++;
    if (wr_go === 1'b1) n_go++;
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic cmd(input logic [31:0] d, input int nbits);
    u_host.frame(d, nbits, rx);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 5000 && status[0] !== 1'b0; i++) @(posedge clk_i);
    `CHECK(status[0], 1'b0)
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    `CHECK(status, 8'h00)
    `CHECK(so_oe_n, 1'b1)
  endtask

  task automatic t_latch();
    cmd(`CMD_LATCH_SET, 8);
    `CHECK(status[1], 1'b1)
    // A second byte after a latch command must not be decoded as a new command.
    cmd({`CMD_LATCH_CLEAR, `CMD_STATUS_WRITE}, 16);
    `CHECK(status[1:0], 2'b10)
    // One clock short of a byte must leave the latch alone.
    cmd(`CMD_LATCH_CLEAR >> 1, 7);
    `CHECK(status[1], 1'b1)
    cmd(`CMD_LATCH_CLEAR, 8);
    `CHECK(status[1], 1'b0)
  endtask

  task automatic t_status_write();
    int r0;
    r0 = n_ref;
    cmd({`CMD_STATUS_WRITE, 8'h8C}, 16);
    `CHECK(n_ref - r0, 1)
    `CHECK(status, 8'h00)
    cmd(`CMD_LATCH_SET, 8);
    cmd({`CMD_STATUS_WRITE, 8'h8C}, 16);
    `CHECK(status[0], 1'b1)
    cmd({`CMD_STATUS_READ, 8'h00}, 16);
    `CHECK(rx[0], 1'b1)
    wait_idle();
    `CHECK(status, 8'h8C)
    cmd({`CMD_STATUS_READ, 8'h00}, 16);
    `CHECK(rx, 8'h8C)
  endtask

  task automatic t_hw_protect();
    int r0;
    r0 = n_ref;
    wp_n <= 1'b0;
    cmd(`CMD_LATCH_SET, 8);
    `CHECK(status[1], 1'b1)
    cmd({`CMD_STATUS_WRITE, 8'h00}, 16);
    `CHECK(n_ref - r0, 1)
    `CHECK(status & 8'hFC, 8'h8C)
    cmd({`CMD_ARRAY_WRITE, 16'h0000, 8'h5A}, 32);
    `CHECK(n_ref - r0, 2)
    cmd(`CMD_LATCH_CLEAR, 8);
    `CHECK(status[1], 1'b0)
    wp_n <= 1'b1;
    cmd(`CMD_LATCH_SET, 8);
    cmd({`CMD_STATUS_WRITE, 8'h84}, 16);
    // The pin falls after the cycle has begun and must not stop it; it stays
    // low for the array scenario, where array writes must still go through.
    wp_n <= 1'b0;
    wait_idle();
    `CHECK(status, 8'h84)
    `CHECK(status[7:2], 6'h21)
  endtask

  task automatic t_array();
    int r0;
    int g0;
    r0 = n_ref;
    g0 = n_go;
    cmd(`CMD_LATCH_SET, 8);
    cmd({`CMD_ARRAY_WRITE, 16'h1800, 8'h11}, 32);
    `CHECK(n_ref - r0, 1)
    cmd(`CMD_LATCH_SET, 8);
    cmd({`CMD_ARRAY_WRITE, 16'h17FF, 8'h22}, 32);
    `CHECK(n_go - g0, 1)
    `CHECK(wr_addr, 13'h17FF)
    `CHECK(status[0], 1'b1)
    cmd(`CMD_LATCH_SET, 8);
    cmd({`CMD_ARRAY_WRITE, 16'h0000, 8'h33}, 32);
    // A status write while busy is dropped silently, latch or not.
    cmd({`CMD_STATUS_WRITE, 8'h00}, 16);
    `CHECK(n_go - g0, 1)
    `CHECK(n_ref - r0, 1)
    wait_idle();
    `CHECK(status, 8'h84)
  endtask

  task automatic finish_test();
    $display("Comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    t_reset();
    t_latch();
    t_status_write();
    t_hw_protect();
    t_array();
    finish_test();
  end
endmodule

// >>> verilog/eeprom_guard.sv
// Status register, write latch and write protection of a serial EEPROM.
`timescale 1ns/1ns
`include "eeprom_guard_regs.svh"
module eeprom_guard #(
  parameter int unsigned WRITE_CYC = `WRITE_TIME_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Serial pins
  input  wire logic        sck_i,
  input  wire logic        cs_n_i,
  input  wire logic        si_i,
  input  wire logic        wp_n_i,
  output logic             so_o,
  output logic             so_oe_n_o,
  // Status and array write control
  output logic [7:0]       status_o,
  output logic             array_wr_go_o,
  output logic [12:0]      array_wr_addr_o,
  output logic             write_refused_o
);
  import eeprom_guard_pkg::*;

  localparam logic [19:0] BUSY_LOAD = 20'(WRITE_CYC - 1);

  eeprom_guard_pkg::core_t st_reg;
  eeprom_guard_pkg::core_t st_next;
  logic [3:0] pins_s;
  logic       sck_s;
  logic       cs_n_s;
  logic       si_s;
  logic       wp_n_s;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_fall;
  logic       cs_rise;
  logic       hw_prot;
  logic [7:0] status_now;
  logic [7:0] byte_in;

  // ----------------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------------
  pin_sync #(.WIDTH(4)) u_sync (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .pin_i     ({sck_i, cs_n_i, si_i, wp_n_i}),
    .rst_val_i (4'hF),
    .sync_o    (pins_s)
  );

  assign sck_s  = pins_s[3];
  assign cs_n_s = pins_s[2];
  assign si_s   = pins_s[1];
  assign wp_n_s = pins_s[0];

  assign sck_rise = sck_s & ~st_reg.sck_prev & ~cs_n_s;
  assign sck_fall = ~sck_s & st_reg.sck_prev & ~cs_n_s;
  assign cs_fall  = ~cs_n_s & st_reg.cs_prev;
  assign cs_rise  = cs_n_s & ~st_reg.cs_prev;
  assign hw_prot  = ~wp_n_s & st_reg.gpe;
  assign byte_in  = {st_reg.sh[6:0], si_s};

  always_comb begin
    status_now                = 8'h00;
    status_now[`ST_GPE_BIT]   = st_reg.gpe;
    status_now[`ST_BG_HI_BIT] = st_reg.bg[1];
    status_now[`ST_BG_LO_BIT] = st_reg.bg[0];
    status_now[`ST_LATCH_BIT] = st_reg.latch;
    status_now[`ST_BUSY_BIT]  = st_reg.busy;
  end

  function automatic logic in_guard(input logic [12:0] a, input logic [1:0] g);
    case (g)
      2'h0:    in_guard = 1'b0;
      2'h1:    in_guard = (a >= `PROT_QTR_BASE);
      2'h2:    in_guard = (a >= `PROT_HALF_BASE);
      default: in_guard = 1'b1;
    endcase
  endfunction

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.wr_go    = 1'b0;
    st_next.refused  = 1'b0;
    st_next.sck_prev = sck_s;
    st_next.cs_prev  = cs_n_s;

    // Completion runs first so that a latch command closing in the same
    // cycle still has the final say over the latch.
    if (st_reg.busy) begin
      if (st_reg.busy_cnt == 20'h0) begin
        st_next.busy   = 1'b0;
        st_next.latch  = 1'b0;
        st_next.sr_cyc = 1'b0;
        if (st_reg.sr_cyc) begin
          st_next.gpe = st_reg.pend[2];
          st_next.bg  = st_reg.pend[1:0];
        end
      end else begin
        st_next.busy_cnt = st_reg.busy_cnt - 20'h1;
      end
    end

    if (cs_fall) begin
      st_next.state    = ST_CMD;
      st_next.bit_cnt  = 3'h0;
      st_next.byte_cnt = 6'h0;
    end else if (cs_rise) begin
      // Only a frame ending on a byte boundary acts; latch and status commands need the exact count, an array write four or more bytes.
      if (st_reg.state != ST_IDLE && st_reg.bit_cnt == 3'h0) begin
        case (st_reg.cmd)
          `CMD_LATCH_SET: begin
            if (st_reg.byte_cnt == 6'h1) st_next.latch = 1'b1;
          end
          `CMD_LATCH_CLEAR: begin
            if (st_reg.byte_cnt == 6'h1) st_next.latch = 1'b0;
          end
          `CMD_STATUS_WRITE: begin
            if (st_reg.byte_cnt == 6'h2 && !st_reg.busy) begin
              if (st_reg.latch && !hw_prot) begin
                st_next.pend     = {st_reg.sr_data[`ST_GPE_BIT],
                                    st_reg.sr_data[`ST_BG_HI_BIT],
                                    st_reg.sr_data[`ST_BG_LO_BIT]};
                st_next.sr_cyc   = 1'b1;
                st_next.busy     = 1'b1;
                st_next.busy_cnt = BUSY_LOAD;
              end else begin
                st_next.refused = 1'b1;
              end
            end
          end
          `CMD_ARRAY_WRITE: begin
            if (st_reg.state == ST_WR && st_reg.byte_cnt >= 6'h4) begin
              if (st_reg.latch && !in_guard(st_reg.addr[12:0], st_reg.bg)) begin
                st_next.wr_go    = 1'b1;
                st_next.wr_addr  = st_reg.addr[12:0];
                st_next.busy     = 1'b1;
                st_next.busy_cnt = BUSY_LOAD;
              end else begin
                st_next.refused = 1'b1;
              end
            end
          end
          default: begin
          end
        endcase
      end
      st_next.state   = ST_IDLE;
      st_next.so_oe_n = 1'b1;
    end else if (st_reg.state != ST_IDLE && st_reg.state != ST_SKIP && sck_rise) begin
      st_next.sh      = byte_in;
      st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
      if (st_reg.bit_cnt == 3'h7) begin
        if (st_reg.byte_cnt != 6'h3F) st_next.byte_cnt = st_reg.byte_cnt + 6'h1;
        case (st_reg.state)
          ST_CMD: begin
            // Only the first byte is a command, so an overlong latch frame cannot
            // turn its second byte into a write.
            if (st_reg.byte_cnt == 6'h0) begin
              st_next.cmd = byte_in;
              case (byte_in)
                `CMD_STATUS_READ: begin
                  st_next.state  = ST_SR_OUT;
                  st_next.out_sh = status_now;
                end
                `CMD_STATUS_WRITE: st_next.state = ST_SR_IN;
                `CMD_ARRAY_WRITE:  st_next.state = st_reg.busy ? ST_SKIP : ST_WR;
                `CMD_LATCH_SET,
                `CMD_LATCH_CLEAR:  st_next.state = ST_CMD;
                default:           st_next.state = ST_SKIP;
              endcase
            end
          end
          ST_SR_IN: begin
            if (st_reg.byte_cnt == 6'h1) st_next.sr_data = byte_in;
          end
          ST_WR: begin
            if (st_reg.byte_cnt == 6'h1) st_next.addr[15:8] = byte_in;
            if (st_reg.byte_cnt == 6'h2) st_next.addr[7:0] = byte_in;
          end
          ST_SR_OUT: st_next.out_sh = status_now;
          default: begin
          end
        endcase
      end
    end else if (st_reg.state == ST_SR_OUT && sck_fall) begin
      st_next.so      = st_reg.out_sh[7];
      st_next.out_sh  = {st_reg.out_sh[6:0], 1'b0};
      st_next.so_oe_n = 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg          <= '0;
      st_reg.state    <= ST_IDLE;
      st_reg.sck_prev <= 1'b1;
      st_reg.cs_prev  <= 1'b1;
      st_reg.so_oe_n  <= 1'b1;
      st_reg.latch    <= 1'b0;
      st_reg.gpe      <= `NV_GPE_RST;
      st_reg.bg       <= `NV_BG_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign so_o            = st_reg.so;
  assign so_oe_n_o       = st_reg.so_oe_n;
  assign status_o        = {st_reg.gpe, 3'h0, st_reg.bg, st_reg.latch, st_reg.busy};
  assign array_wr_go_o   = st_reg.wr_go;
  assign array_wr_addr_o = st_reg.wr_addr;
  assign write_refused_o = st_reg.refused;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_reserved_bits_zero: assert property (status_o[6:4] == 3'h0)
    else $error("status reserved bits not zero");

  a_start_needs_latch: assert property ($rose(st_reg.busy) |-> $past(st_reg.latch))
    else $error("write cycle started without latch");

  a_busy_load_value: assert property ($rose(st_reg.busy) |-> st_reg.busy_cnt == BUSY_LOAD)
    else $error("busy counter loaded wrongly");

  a_busy_holds_on: assert property (st_reg.busy && st_reg.busy_cnt != 20'h0 |=> st_reg.busy)
    else $error("busy dropped early");

  a_done_clears_latch: assert property (
    $fell(st_reg.busy) && !$past(cs_rise) |-> !st_reg.latch)
    else $error("latch survived write completion");

  a_hw_guard_blocks: assert property (
    cs_rise && st_reg.cmd == `CMD_STATUS_WRITE && hw_prot && !st_reg.busy
      |=> !st_reg.busy && !st_reg.sr_cyc)
    else $error("status write accepted under hardware protection");

  a_guard_range: assert property (
    st_reg.wr_go |-> !in_guard(st_reg.wr_addr, st_reg.bg))
    else $error("write started into guarded block");

  a_busy_ignores: assert property (
    st_reg.busy && st_reg.busy_cnt > 20'h1 |=> !st_reg.wr_go)
    else $error("array write taken while busy");

  a_latch_set_cmd: assert property (
    cs_rise && st_reg.state == ST_CMD && st_reg.cmd == `CMD_LATCH_SET
      && st_reg.byte_cnt == 6'h1 && st_reg.bit_cnt == 3'h0 |=> st_reg.latch)
    else $error("latch set command had no effect");

  a_standby_so_off: assert property (st_reg.state == ST_IDLE |-> so_oe_n_o)
    else $error("serial output driven in standby");

endmodule

// >>> verilog/eeprom_guard_pkg.sv
// Types shared by the status and write-protection block.
package eeprom_guard_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CMD    = 3'b001,
    ST_WR     = 3'b010,
    ST_SR_OUT = 3'b011,
    ST_SR_IN  = 3'b100,
    ST_SKIP   = 3'b101
  } phase_t;

  typedef struct packed {
    phase_t      state;
    logic        sck_prev;
    logic        cs_prev;
    logic [7:0]  sh;
    logic [2:0]  bit_cnt;
    logic [5:0]  byte_cnt;
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  sr_data;
    logic [7:0]  out_sh;
    logic        so;
    logic        so_oe_n;
    logic        latch;
    logic        gpe;
    logic [1:0]  bg;
    logic [2:0]  pend;
    logic        sr_cyc;
    logic        busy;
    logic [19:0] busy_cnt;
    logic        wr_go;
    logic [12:0] wr_addr;
    logic        refused;
  } core_t;

endpackage

// >>> verilog/eeprom_guard_regs.svh
// Constants of the serial EEPROM status and write-protection block.
`ifndef EEPROM_GUARD_REGS_SVH
`define EEPROM_GUARD_REGS_SVH

// ----------------------------------------------------------------------------
// Commands
// ----------------------------------------------------------------------------
`define CMD_ARRAY_READ     8'h03
`define CMD_ARRAY_WRITE    8'h02
`define CMD_LATCH_SET      8'h06
`define CMD_LATCH_CLEAR    8'h04
`define CMD_STATUS_READ    8'h05
`define CMD_STATUS_WRITE   8'h01

// ----------------------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------------------
`define ST_GPE_BIT         7
`define ST_BG_HI_BIT       3
`define ST_BG_LO_BIT       2
`define ST_LATCH_BIT       1
`define ST_BUSY_BIT        0
`define NV_GPE_RST         1'b0
`define NV_BG_RST          2'h0

// ----------------------------------------------------------------------------
// Array protection bounds and timing
// ----------------------------------------------------------------------------
`define PROT_QTR_BASE      13'h1800
`define PROT_HALF_BASE     13'h1000
`define CLK_PERIOD_NS      10
`define WRITE_TIME_NS      5000000

`endif

// >>> verilog/pin_sync.sv
// Two-flop synchroniser for pins arriving from outside the clock domain.
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Pins and their synchronised copies
  input  wire logic [WIDTH-1:0] pin_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // Reset holds ones so that an idle select reads deselected.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= '1;
      sync_o   <= '1;
    end else begin
      meta_reg <= pin_i;
      sync_o   <= meta_reg;
    end
  end

endmodule
